// ===== verilog/eeprom_regs.svh
// Purpose: constants for the two-wire serial memory slave
// Assumes: 10 MHz system clock, bus clock far slower than system clock
// Notes: offsets, field positions, reset values and timing counts only
//
// Behaviour
// - SDA rising while SCL high is Stop; ends current transfer.
// - receiver of a byte pulls SDA low on the ninth clock.
// - Start resets any interrupted transfer; master may clock nine times first.
// - standby after reset, after non-write Stop, after internal write ends.
// - address byte accepted only when top nibble is 1010.
// - block select bit picks one of two 256-byte blocks.
// - two chip-select bits compared with the two chip-select pins.
// - last address bit is direction: 1 read, 0 write.
// - on address match drive SDA low on ninth clock, then continue.
// - byte write: address, word address, data, each acked; program at Stop.
// - ignore every master request while internal programming runs.
// - page write takes up to 15 more bytes, each acked at once.
// - write increments only low four address bits, wrapping inside page.
// - all received page bytes committed together in one write cycle.
// - address byte not acked while busy, acked once write is done.
// - counter holds last address plus one; current read wraps to 0.
// - random read: dummy write of word address, repeated Start, read.
// - each master ack yields next byte; no ack plus Stop ends read.
// - sequential read rolls address counter from top of array to 0.
// - SDA falling while SCL high is Start; silent until one seen.
// - SDA sampled on SCL rise; device changes SDA only while SCL low.
// - write-protect pin high blocks all array writes.
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define EE_ADDR_W 9
`define EE_DEPTH 512
`define EE_PAGE_BYTES 16
`define EE_DEV_TYPE 4'hA
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_CS_HIGH_BIT 3
`define EE_CS_LOW_BIT 2
`define EE_BLOCK_BIT 1
`define EE_DIR_BIT 0
`define EE_LAST_BIT 4'h7
`define EE_BYTE_DONE 4'h8
`define EE_CLK_PERIOD_NS 100
`define EE_WR_CYCLE_NS 5000000
`define EE_ADDR_RST 9'h000

`endif

// ===== verilog/eeprom_pkg.sv
// Purpose: types shared by the serial memory slave
// Assumes: constants header on the include path
// Notes: whole module state is one packed struct
`include "eeprom_regs.svh"

package eeprom_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WORD,
    ST_WORD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_PROG
  } bus_state_e;

  typedef struct packed {
    bus_state_e state;
    logic [1:0] scl_sync;
    logic scl_d;
    logic [1:0] sda_sync;
    logic sda_d;
    logic [1:0] wp_sync;
    logic [1:0] csl_sync;
    logic [1:0] csh_sync;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic rd_dir;
    logic master_ack;
    logic wr_seen;
    logic [`EE_ADDR_W-1:0] addr;
    logic [`EE_ADDR_W-5:0] page_base;
    logic [`EE_PAGE_BYTES-1:0][7:0] page_buf;
    logic [`EE_PAGE_BYTES-1:0] page_mask;
    logic [15:0] timer;
    logic sda_out;
    logic sda_oe_n;
    logic standby;
    logic busy;
    logic [`EE_DEPTH-1:0][7:0] mem;
  } slave_state_s;

endpackage

// ===== verilog/eeprom_slave.sv
// Purpose: two-wire slave front end of a 512 x 8 paged serial memory
// Assumes: bus pins asynchronous to i_clk; SCL high and low each span several clocks
// Notes: SDA is open drain; o_sda_oe_n low means the line is pulled low
`include "eeprom_regs.svh"

module eeprom_slave #(
  parameter int unsigned WR_CYCLES = `EE_WR_CYCLE_NS / `EE_CLK_PERIOD_NS
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic i_chip_select_pin_low,
  input wire logic i_chip_select_pin_high,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_standby,
  output logic o_busy
);

  // does the address byte name this device
  function automatic logic addr_match(input logic [7:0] b, input logic csh, input logic csl);
    addr_match = (b[`EE_TYPE_MSB:`EE_TYPE_LSB] == `EE_DEV_TYPE)
                 && (b[`EE_CS_HIGH_BIT] == csh)
                 && (b[`EE_CS_LOW_BIT] == csl);
  endfunction

  // next address inside the same 16-byte page
  function automatic logic [`EE_ADDR_W-1:0] page_inc(input logic [`EE_ADDR_W-1:0] a);
    page_inc = {a[`EE_ADDR_W-1:4], a[3:0] + 4'h1};
  endfunction

  eeprom_pkg::slave_state_s st;
  eeprom_pkg::slave_state_s next_st;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // edges seen on the second synchroniser stage only
  assign scl = st.scl_sync[1];
  assign sda = st.sda_sync[1];
  assign scl_rise = scl && !st.scl_d;
  assign scl_fall = !scl && st.scl_d;
  assign start_cond = scl && st.scl_d && st.sda_d && !sda;
  assign stop_cond = scl && st.scl_d && !st.sda_d && sda;

  // whole next-state computation
  always_comb begin
    next_st = st;
    next_st.scl_sync = {st.scl_sync[0], i_scl};
    next_st.sda_sync = {st.sda_sync[0], i_sda};
    next_st.wp_sync = {st.wp_sync[0], i_wp};
    next_st.csl_sync = {st.csl_sync[0], i_chip_select_pin_low};
    next_st.csh_sync = {st.csh_sync[0], i_chip_select_pin_high};
    next_st.scl_d = scl;
    next_st.sda_d = sda;
    next_st.sda_out = 1'b0;

    // receive shift on SCL rise in all receiving states
    if (scl_rise && (st.state == eeprom_pkg::ST_ADDR || st.state == eeprom_pkg::ST_WORD
        || st.state == eeprom_pkg::ST_WDATA) && st.bit_cnt != `EE_BYTE_DONE) begin
      next_st.shift = {st.shift[6:0], sda};
      next_st.bit_cnt = st.bit_cnt + 4'h1;
    end

    case (st.state)
      eeprom_pkg::ST_IDLE: begin
        next_st.sda_oe_n = 1'b1;
      end

      // slave address byte
      eeprom_pkg::ST_ADDR: begin
        if (scl_fall && st.bit_cnt == `EE_BYTE_DONE) begin
          if (addr_match(st.shift, st.csh_sync[1], st.csl_sync[1])) begin
            next_st.sda_oe_n = 1'b0;
            next_st.rd_dir = st.shift[`EE_DIR_BIT];
            next_st.addr = {st.shift[`EE_BLOCK_BIT], st.addr[7:0]};
            next_st.state = eeprom_pkg::ST_ADDR_ACK;
          end else begin
            next_st.state = eeprom_pkg::ST_IDLE;
          end
        end
      end

      // release ack, then read or write phase
      eeprom_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          next_st.bit_cnt = 4'h0;
          if (st.rd_dir) begin
            next_st.shift = st.mem[st.addr];
            next_st.sda_oe_n = st.mem[st.addr][7];
            next_st.addr = st.addr + 9'h001;
            next_st.state = eeprom_pkg::ST_RDATA;
          end else begin
            next_st.sda_oe_n = 1'b1;
            next_st.state = eeprom_pkg::ST_WORD;
          end
        end
      end

      // word address byte
      eeprom_pkg::ST_WORD: begin
        if (scl_fall && st.bit_cnt == `EE_BYTE_DONE) begin
          next_st.addr = {st.addr[8], st.shift};
          next_st.page_base = st.addr[8:4];
          next_st.page_base[3:0] = st.shift[7:4];
          next_st.sda_oe_n = 1'b0;
          next_st.state = eeprom_pkg::ST_WORD_ACK;
        end
      end

      eeprom_pkg::ST_WORD_ACK: begin
        if (scl_fall) begin
          next_st.sda_oe_n = 1'b1;
          next_st.bit_cnt = 4'h0;
          next_st.state = eeprom_pkg::ST_WDATA;
        end
      end

      // data bytes collected into the page buffer
      eeprom_pkg::ST_WDATA: begin
        if (scl_fall && st.bit_cnt == `EE_BYTE_DONE) begin
          next_st.page_buf[st.addr[3:0]] = st.shift;
          next_st.page_mask[st.addr[3:0]] = 1'b1;
          next_st.addr = page_inc(st.addr);
          next_st.wr_seen = 1'b1;
          next_st.sda_oe_n = 1'b0;
          next_st.state = eeprom_pkg::ST_WDATA_ACK;
        end
      end

      eeprom_pkg::ST_WDATA_ACK: begin
        if (scl_fall) begin
          next_st.sda_oe_n = 1'b1;
          next_st.bit_cnt = 4'h0;
          next_st.state = eeprom_pkg::ST_WDATA;
        end
      end

      // shift a byte out, msb first, changing on SCL fall
      eeprom_pkg::ST_RDATA: begin
        if (scl_fall) begin
          if (st.bit_cnt == `EE_LAST_BIT) begin
            next_st.sda_oe_n = 1'b1;
            next_st.state = eeprom_pkg::ST_RACK;
          end else begin
            next_st.shift = {st.shift[6:0], 1'b0};
            next_st.sda_oe_n = st.shift[6];
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
        end
      end

      // master ack decides whether another byte follows
      eeprom_pkg::ST_RACK: begin
        if (scl_rise) begin
          next_st.master_ack = !sda;
        end
        if (scl_fall) begin
          next_st.bit_cnt = 4'h0;
          if (st.master_ack) begin
            next_st.shift = st.mem[st.addr];
            next_st.sda_oe_n = st.mem[st.addr][7];
            next_st.addr = st.addr + 9'h001;
            next_st.state = eeprom_pkg::ST_RDATA;
          end else begin
            next_st.state = eeprom_pkg::ST_IDLE;
          end
        end
      end

      // self-timed programming; bus fully ignored
      eeprom_pkg::ST_PROG: begin
        next_st.sda_oe_n = 1'b1;
        next_st.timer = st.timer + 16'h0001;
        if (st.timer == 16'(WR_CYCLES - 1)) begin
          for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
            if (st.page_mask[i]) begin
              next_st.mem[{st.page_base, 4'(i)}] = st.page_buf[i];
            end
          end
          next_st.page_mask = '0;
          next_st.busy = 1'b0;
          next_st.standby = 1'b1;
          next_st.state = eeprom_pkg::ST_IDLE;
        end
      end

      default: begin
        next_st.state = eeprom_pkg::ST_IDLE;
      end
    endcase

    // bus conditions override everything except programming
    if (st.state != eeprom_pkg::ST_PROG) begin
      if (start_cond) begin
        next_st.state = eeprom_pkg::ST_ADDR;
        next_st.bit_cnt = 4'h0;
        next_st.sda_oe_n = 1'b1;
        next_st.standby = 1'b0;
        next_st.wr_seen = 1'b0;
        next_st.page_mask = '0;
      end else if (stop_cond) begin
        next_st.sda_oe_n = 1'b1;
        next_st.wr_seen = 1'b0;
        if (st.wr_seen && !st.wp_sync[1]) begin
          next_st.state = eeprom_pkg::ST_PROG;
          next_st.timer = 16'h0000;
          next_st.busy = 1'b1;
          next_st.standby = 1'b0;
        end else begin
          next_st.state = eeprom_pkg::ST_IDLE;
          next_st.page_mask = '0;
          next_st.standby = 1'b1;
        end
      end
    end

    // synchronous reset of all control state; array contents kept
    if (i_srst) begin
      next_st.state = eeprom_pkg::ST_IDLE;
      next_st.scl_sync = 2'h3;
      next_st.scl_d = 1'b1;
      next_st.sda_sync = 2'h3;
      next_st.sda_d = 1'b1;
      next_st.wp_sync = 2'h0;
      next_st.csl_sync = 2'h0;
      next_st.csh_sync = 2'h0;
      next_st.shift = 8'h00;
      next_st.bit_cnt = 4'h0;
      next_st.rd_dir = 1'b0;
      next_st.master_ack = 1'b0;
      next_st.wr_seen = 1'b0;
      next_st.addr = `EE_ADDR_RST;
      next_st.page_base = 5'h00;
      next_st.page_buf = '0;
      next_st.page_mask = '0;
      next_st.timer = 16'h0000;
      next_st.sda_oe_n = 1'b1;
      next_st.standby = 1'b1;
      next_st.busy = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  // outputs straight from state flops
  assign o_sda_out = st.sda_out;
  assign o_sda_oe_n = st.sda_oe_n;
  assign o_standby = st.standby;
  assign o_busy = st.busy;

endmodule // eeprom_slave

// ===== tb/eeprom_slave_sva.sv
// Purpose: port checks for the memory slave
// Assumes: bound to every eeprom_slave
// Notes: busy length follows WR_CYCLES
module eeprom_slave_sva #(
  parameter int unsigned WR_CYCLES = 200
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_standby,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] bcnt;
  logic [3:0] since_stop;
  logic sda_q;
  // busy cycles and clocks since the last stop
  always_ff @(posedge i_clk) begin
    sda_q <= i_sda;
    bcnt <= o_busy ? bcnt + 32'h1 : 32'h0;
    if (i_scl && i_sda && !sda_q) begin
      since_stop <= 4'h0;
    end else if (since_stop != 4'hF) begin
      since_stop <= since_stop + 4'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_out_zero; o_sda_out == 1'b0; endproperty
  a_out_zero: assert property (p_out_zero) else $error("sda out high");
  property p_busy_sb; o_busy |-> !o_standby; endproperty
  a_busy_sb: assert property (p_busy_sb) else $error("standby in write");
  property p_busy_quiet; o_busy |-> o_sda_oe_n; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive in write");
  property p_oe_scl_low; $changed(o_sda_oe_n) |-> !i_scl; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
  property p_busy_len; $fell(o_busy) |-> bcnt >= WR_CYCLES - 1 && bcnt <= WR_CYCLES + 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write length");
  property p_busy_max; bcnt <= WR_CYCLES + 1; endproperty
  a_busy_max: assert property (p_busy_max) else $error("write too long");
  property p_end_sb; $fell(o_busy) |-> o_standby; endproperty
  a_end_sb: assert property (p_end_sb) else $error("no standby");
  property p_after_stop; $rose(o_busy) |-> since_stop < 4'h8; endproperty
  a_after_stop: assert property (p_after_stop) else $error("write w/o stop");
  property p_reset_idle; $fell(i_srst) |-> o_sda_oe_n && o_standby && !o_busy; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset state");
  c_write: cover property ($rose(o_busy));
  c_ack: cover property ($fell(o_sda_oe_n));
  c_done: cover property ($fell(o_busy));
endmodule // eeprom_slave_sva

bind eeprom_slave eeprom_slave_sva #(.WR_CYCLES(WR_CYCLES)) u_sva (.i_clk(i_clk),
  .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe_n(o_sda_oe_n), .o_standby(o_standby), .o_busy(o_busy));

// ===== tb/twi_master.sv
// Purpose: bus master model for SCL and SDA
// Assumes: 800 ns bit on a 100 ns clock
// Notes: SDA only pulled low or released
module twi_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;
  event got_ev;
  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  task automatic q();
    repeat (2) @(posedge i_clk);
  endtask
  // one pulse: data set while low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    o_scl <= 1'b0;
    q();
    o_sda_rel <= b;
    q();
    o_scl <= 1'b1;
    q();
    s = i_sda;
    q();
  endtask
  task automatic start();
    o_scl <= 1'b0;
    q();
    o_sda_rel <= 1'b1;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_rel <= 1'b0;
    q();
  endtask
  task automatic stop();
    o_scl <= 1'b0;
    q();
    o_sda_rel <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_rel <= 1'b1;
    q();
  endtask
  // byte out msb first, ninth clock gives ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = (s === 1'b0);
  endtask
  // byte in, then ack or no ack
  task automatic rbyte(input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      got[i] = s;
    end
    bit_io(!mack, s);
    ->got_ev;
  endtask
endmodule // twi_master

// ===== tb/eeprom_slave_test.sv
// Purpose: self-checking bench for the memory slave
// Assumes: write cycle shortened to 200 clocks
// Notes: read bytes checked by a queue watcher
module eeprom_slave_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wp = 1'b0;
  logic csl = 1'b0;
  logic csh = 1'b0;
  logic scl, rel, oe_n, sda_o, sb, busy, ack;
  wire sda = rel & (oe_n | sda_o);
  logic [7:0] exp_mem [512];
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'h00A1;
  int fail_count = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  twi_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(rel));
  eeprom_slave #(.WR_CYCLES(200)) dut (.i_clk(clk), .i_srst(srst), .i_scl(scl),
    .i_sda(sda), .i_wp(wp), .i_chip_select_pin_low(csl), .i_chip_select_pin_high(csh),
    .o_sda_out(sda_o), .o_sda_oe_n(oe_n), .o_standby(sb), .o_busy(busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic dev(input logic [8:0] a, input logic rd);
    m.wbyte({4'hA, csh, csl, a[8], rd}, ack);
  endtask
  // page write, then ack polling
  task automatic wr(input logic [8:0] a, input int n);
    m.start();
    dev(a, 1'b0);
    chk(ack, "addr nak");
    m.wbyte(a[7:0], ack);
    chk(ack, "word nak");
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      if (!wp) exp_mem[{a[8:4], a[3:0] + i[3:0]}] = seed[7:0];
      m.wbyte(seed[7:0], ack);
      chk(ack, "data nak");
    end
    m.stop();
    for (int k = 0; k < 40; k++) begin
      m.start();
      dev(a, 1'b0);
      if (k == 0 && !wp) chk(!ack, "ack in write");
      if (ack) break;
      if (k == 39) begin
        chk(1'b0, "poll timeout");
        finish_test();
      end
    end
    m.stop();
  endtask
  // random or current read of n bytes
  task automatic rd(input logic [8:0] a, input int n, input logic cur);
    m.start();
    if (!cur) begin
      dev(a, 1'b0);
      m.wbyte(a[7:0], ack);
      chk(ack, "word nak");
      m.start();
    end
    dev(a, 1'b1);
    chk(ack, "read nak");
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(exp_mem[9'(a + i)]);
      m.rbyte(i < n - 1);
    end
    m.stop();
  endtask
  // compare each read byte with the oldest note
  always @(m.got_ev) begin
    check_count++;
    if (exp_q.size() == 0 || m.got !== exp_q.pop_front()) begin
      fail_count++;
      $display("[ERR] %0t read %h", $time, m.got);
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(oe_n === 1'b1 && sb === 1'b1 && busy === 1'b0, "reset");
    $display("reset test done");
    wr(9'h1F0, 16);
    wr(9'h000, 18);
    rd(9'h1F0, 32, 1'b0);
    rd(9'h1FE, 1, 1'b0);
    rd(9'h1FF, 1, 1'b1);
    $display("page and read tests done");
    m.start();
    m.wbyte({4'hA, !csh, csl, 2'b00}, ack);
    chk(!ack, "cs ack");
    m.start();
    m.wbyte({4'h5, csh, csl, 2'b00}, ack);
    chk(!ack, "type ack");
    m.stop();
    csh <= 1'b1;
    @(posedge clk);
    wr(9'h0A5, 1);
    rd(9'h0A5, 1, 1'b0);
    $display("address test done");
    wp <= 1'b1;
    @(posedge clk);
    wr(9'h1F0, 1);
    rd(9'h1F0, 1, 1'b0);
    $display("protect test done");
    finish_test();
  end
endmodule // eeprom_slave_test
